// *** test/dds_far_end.sv ***
// Far-end bus model: grants a channel request after a set delay.
// Assumes level requests that drop once the grant has been seen.
`timescale 1ns/1ps
`default_nettype none
module dds_far_end #(parameter int DLY = 2) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic req_i,
	output logic ack_o
);
	int n;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			n <= 0;
			ack_o <= 1'b0;
		end else if (!req_i) begin
			n <= 0;
			ack_o <= 1'b0;
		end else begin
			n <= n + 1;
			ack_o <= (n >= DLY);
		end
	end
endmodule
`default_nettype wire

// *** test/dds_sequencer_bench.sv ***
// Bench for the dual-channel DMA sequencer: register tasks and scenarios.
// Assumes two far-end models granting the local and remote requests.
`timescale 1ns/1ps
`default_nettype none
module dds_sequencer_bench;
	import dds_pkg::*;
	`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin error_cnt++; $display("BAD %0t %h %h",$time,a,b); end end
	logic clk = 0, rst = 1, wr = 0, rd = 0, idx = 0, fneed = 0, derr = 0, ps = 0, ews = 0, sdone = 0;
	logic local_bus_ack, rack, lreq, rreq, lstb, rstb, drun, irq;
	logic [3:0] ra = 0;
	logic [7:0] wd = 0, rdata, d;
	logic [15:0] laddr, raddr, ha;
	int error_cnt = 0, n_tests = 0, np = 0, nh = 0, cyc = 0, s, k;
	dds_sequencer uut (.clk_i(clk), .sys_rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .local_bus_ack_i(local_bus_ack), .remote_bus_ack_i(rack),
		.ext_status_i(ews), .index_pulse_i(idx), .fifo_need_i(fneed), .sector_done_i(sdone),
		.disk_error_i(derr), .local_bus_request_o(lreq), .remote_bus_request_o(rreq),
		.local_strobe_o(lstb), .remote_strobe_o(rstb), .local_addr_o(laddr), .remote_addr_o(raddr),
		.disk_run_o(drun), .irq_o(irq));
	dds_far_end #(.DLY(1)) far_l (.clk_i(clk), .sys_rst_i(rst), .req_i(lreq), .ack_o(local_bus_ack));
	dds_far_end #(.DLY(6)) far_r (.clk_i(clk), .sys_rst_i(rst), .req_i(rreq), .ack_o(rack));
	initial forever #5 clk = ~clk;
	// Strobe pulse and cycle counts, hang limit
	always @(posedge clk) begin
		cyc++;
		if (rstb === 1'b1) nh++;
		if (rstb === 1'b1 && ps !== 1'b1) np++;
		ps = rstb;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task summarize;
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wr8(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		ra <= a;
		wd <= v;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd8(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		ra <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 v = rdata;
	endtask
	task wr16(input logic [3:0] a, input logic [15:0] v);
		wr8(a, v[7:0]);
		wr8(a + 4'h1, v[15:8]);
	endtask
	task go(input logic [15:0] a, input logic [15:0] c, input logic [7:0] x, input logic [7:0] oc);
		np = 0;
		nh = 0;
		wr16(OFS_RADDR0, a);
		wr8(OFS_RXFER, x);
		wr16(OFS_RCNT0, c);
		wr8(OFS_OPCMD, oc);
	endtask
	task wirq;
		for (s = 0; s < 3000 && irq !== 1'b1; s++) @(posedge clk);
		#1 `CHK(irq, 1'b1) // completion interrupt
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		#1 `CHK({lreq, rreq, irq}, 3'h0) // no request unasked
		wr8(4'hF, 8'hFF);
		rd8(4'hF, d);
		`CHK(d, 8'h00)
		go(16'h1234, 16'h0003, 8'h01, 8'h05);
		wirq(); // input done interrupt
		`CHK(np, 4) // odd count rounded up
		`CHK(nh, 16) // four-period cycle
		`CHK(raddr, 16'h1238) // byte step
		rd8(OFS_STATUS, d);
		`CHK(d[ST_RDONE], 1'b1) // remote done flag
		repeat (2) @(posedge clk);
		#1 `CHK(irq, 1'b0) // cleared by read
		go(16'h2000, 16'h0005, 8'h07, 8'h06);
		wirq(); // output transfer ends
		`CHK(np, 3) // odd count rounded up
		`CHK(nh, 15) // five-period slow cycle
		`CHK(raddr, 16'h2006) // word step
		rd8(OFS_STATUS, d);
		go(16'h3000, 16'h0010, 8'h01, 8'h05);
		for (s = 0; s < 3000 && np < 3; s++) @(posedge clk);
		wr8(OFS_OPCMD, 8'h07);
		repeat (40) @(posedge clk);
		ha = raddr;
		k = np;
		repeat (100) @(posedge clk);
		`CHK(raddr, ha) // address kept
		`CHK(np, k) // no transfer while halted
		rd8(OFS_STATUS, d);
		`CHK(d[ST_HALTED], 1'b1) // halt flagged
		wr8(OFS_OPCMD, 8'h05);
		wirq(); // resumed transfer ends
		`CHK(np, 16) // no restart from start
		`CHK(raddr, 16'h3010) // last address reached
		rd8(OFS_STATUS, d);
		@(posedge clk);
		ews <= 1;
		go(16'h4000, 16'h0001, 8'h09, 8'h05);
		for (s = 0; s < 500 && rstb !== 1'b1; s++) @(posedge clk);
		repeat (10) @(posedge clk);
		ews <= 0;
		wirq(); // held cycle ends
		`CHK(np, 2) // one byte rounded to two
		`CHK(nh > 12, 1'b1) // wait extends cycle
		rd8(OFS_STATUS, d);
		wr16(OFS_LADDR0, 16'h0100);
		wr8(OFS_LXFER, 8'h01);
		wr16(OFS_LCNT0, 16'h0002);
		wr8(OFS_SECOPS, 8'h01);
		wr8(OFS_SECCNT, 8'h01);
		fneed <= 1;
		wr8(OFS_DRVCMD, 8'h01);
		repeat (30) @(posedge clk);
		#1 `CHK(lreq, 1'b0) // held off until index
		@(posedge clk);
		idx <= 1;
		repeat (4) @(posedge clk);
		idx <= 0;
		for (s = 0; s < 50 && lreq !== 1'b1; s++) @(posedge clk);
		#1 `CHK(lreq, 1'b1) // local request raised
		`CHK(drun, 1'b1) // disk operation active
		repeat (30) @(posedge clk);
		derr <= 1;
		@(posedge clk);
		derr <= 0;
		wirq(); // local transfer done interrupt
		rd8(OFS_STATUS, d);
		wr8(OFS_LXFER, 8'h81);
		wr8(OFS_OPCMD, 8'h04);
		wr8(OFS_DRVCMD, 8'h05);
		repeat (3) @(posedge clk);
		#1 `CHK(lreq, 1'b1) // request on FIFO need
		`CHK(lstb, 1'b0) // internal DMA unused
		@(posedge clk);
		sdone <= 1;
		@(posedge clk);
		sdone <= 0;
		wirq(); // external operation completes
		`CHK(drun, 1'b0) // operation ended
		summarize();
	end
endmodule
`default_nettype wire

// *** verilog/dds_channel.sv ***
// One DMA channel engine: request/acknowledge handshake, bus cycle timing,
// address step and count. Assumes a synchronised ack and ext-wait input.
`timescale 1ns/1ps
`default_nettype none
module dds_channel (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic load_addr_i,
	input wire logic [15:0] addr_i,
	input wire logic load_cnt_i,
	input wire logic [15:0] cnt_i,
	input wire logic word_i,
	input wire logic slow_i,
	input wire logic extwait_en_i,
	input wire logic extwait_i,
	input wire logic ack_i,
	output logic req_o,
	output logic strobe_o,
	output logic [15:0] addr_o,
	output logic [15:0] cnt_o,
	output logic done_o
);
	import dds_pkg::*;

	dds_ch_state_t state_reg, state_next;
	logic [2:0] phase_reg;
	logic [15:0] addr_reg, cnt_reg;
	logic req_reg, strobe_reg, done_reg;
	logic [2:0] cyc_len;
	logic [15:0] step;
	logic cyc_end, last_xfer, wait_hold;
	logic ack_low_reg;

	assign cyc_len = slow_i ? CYC_SLOW : CYC_NORMAL;
	assign step = word_i ? STEP_WORD : STEP_BYTE;
	assign wait_hold = extwait_en_i & extwait_i;
	assign cyc_end = (phase_reg == cyc_len - 3'h1) & ~wait_hold;
	assign last_xfer = cnt_reg <= step;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CH_IDLE: if (run_i && cnt_reg != '0) state_next = CH_REQ;
			CH_REQ: if (!run_i) state_next = CH_IDLE;
				else if (ack_i && ack_low_reg) state_next = CH_CYC;
			CH_CYC: if (cyc_end) state_next = last_xfer ? CH_DONE : (run_i ? CH_REQ : CH_IDLE);
			CH_DONE: state_next = CH_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= CH_IDLE;
			phase_reg <= '0;
			ack_low_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			// only a fresh ack, old level may linger in sync
			ack_low_reg <= ~ack_i | (ack_low_reg & ~(state_reg == CH_REQ & ack_i));
			phase_reg <= (state_reg == CH_CYC && !cyc_end && !wait_hold) ? phase_reg + 3'h1 :
				(state_reg == CH_CYC && wait_hold) ? phase_reg : '0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_reg <= '0;
			cnt_reg <= '0;
		end else if (load_addr_i || load_cnt_i) begin
			if (load_addr_i) addr_reg <= addr_i;
			if (load_cnt_i) cnt_reg <= (cnt_i + CNT_ONE) & CNT_ODD_MASK;
		end else if (state_reg == CH_CYC && cyc_end) begin
			addr_reg <= addr_reg + step;
			cnt_reg <= last_xfer ? '0 : cnt_reg - step;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			req_reg <= 1'b0;
			strobe_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			req_reg <= state_next == CH_REQ;
			strobe_reg <= state_next == CH_CYC;
			done_reg <= state_next == CH_DONE;
		end
	end

	assign req_o = req_reg;
	assign strobe_o = strobe_reg;
	assign addr_o = addr_reg;
	assign cnt_o = cnt_reg;
	assign done_o = done_reg;

	property p_cyc_after_ack;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(strobe_reg) |-> $past(ack_i) && $past(req_reg);
	endproperty
	a_cyc_after_ack: assert property (p_cyc_after_ack) else $error("bus cycle without ack");

	property p_req_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		req_reg && !ack_i && run_i |=> req_reg;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped early");

	property p_step;
		@(posedge clk_i) disable iff (sys_rst_i)
		state_reg == CH_CYC && cyc_end && !load_addr_i && !load_cnt_i |=> addr_reg == $past(addr_reg) + $past(step);
	endproperty
	a_step: assert property (p_step) else $error("address step wrong");

	property p_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		state_reg != CH_CYC && !load_addr_i |=> $stable(addr_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved while idle");

	property p_even;
		@(posedge clk_i) disable iff (sys_rst_i)
		load_cnt_i |=> cnt_reg[0] == 1'b0;
	endproperty
	a_even: assert property (p_even) else $error("count not even");

	property p_normal_len;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(strobe_reg) && !slow_i && !extwait_en_i |-> strobe_reg [*4] ##1 !strobe_reg;
	endproperty
	a_normal_len: assert property (p_normal_len) else $error("cycle not four periods");

	property p_slow_len;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(strobe_reg) && slow_i && !extwait_en_i |-> strobe_reg [*5] ##1 !strobe_reg;
	endproperty
	a_slow_len: assert property (p_slow_len) else $error("slow cycle not five periods");
endmodule
`default_nettype wire

// *** verilog/dds_pkg.sv ***
// Package for the dual-channel DMA sequencer: register map, fields, timing.
// Assumes a single 100 MHz system clock and a byte-wide register port.
package dds_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] DDS_ADDR_WIDTH_C = 4'h4;
	localparam logic [3:0] OFS_LADDR0 = 4'h0;
	localparam logic [3:0] OFS_LADDR1 = 4'h1;
	localparam logic [3:0] OFS_RADDR0 = 4'h2;
	localparam logic [3:0] OFS_RADDR1 = 4'h3;
	localparam logic [3:0] OFS_LXFER = 4'h4;
	localparam logic [3:0] OFS_RXFER = 4'h5;
	localparam logic [3:0] OFS_RCNT0 = 4'h6;
	localparam logic [3:0] OFS_RCNT1 = 4'h7;
	localparam logic [3:0] OFS_LCNT0 = 4'h8;
	localparam logic [3:0] OFS_LCNT1 = 4'h9;
	localparam logic [3:0] OFS_SECOPS = 4'hA;
	localparam logic [3:0] OFS_SECCNT = 4'hB;
	localparam logic [3:0] OFS_OPCMD = 4'hC;
	localparam logic [3:0] OFS_DRVCMD = 4'hD;
	localparam logic [3:0] OFS_STATUS = 4'hE;
	// ---------------------------------------------------------------
	// Transfer register fields (track only remote, external DMA only local; ext-wait from the remote register)
	// ---------------------------------------------------------------
	localparam int XF_ENABLE = 0;
	localparam int XF_WORD = 1;
	localparam int XF_SLOW = 2;
	localparam int XF_EXTWAIT = 3;
	localparam int XF_SWAP = 4;
	localparam int XF_LONGADDR = 5;
	localparam int XF_TRACK = 6;
	localparam int XF_EXTDMA = 7;
	// ---------------------------------------------------------------
	// Operation command and drive command fields
	// ---------------------------------------------------------------
	localparam int OC_RIN = 0;
	localparam int OC_ROUT = 1;
	localparam int OC_INTEN = 2;
	localparam int DC_WRITE = 0;
	localparam int DC_READ = 1;
	localparam int DC_START_AT_INDEX_CTL = 2;
	// ---------------------------------------------------------------
	// Status fields
	// ---------------------------------------------------------------
	localparam int ST_OPDONE = 0;
	localparam int ST_RDONE = 1;
	localparam int ST_RBUSY = 2;
	localparam int ST_LBUSY = 3;
	localparam int ST_HALTED = 4;
	localparam int ST_WAITIDX = 5;
	// ---------------------------------------------------------------
	// Bus cycle timing in clock periods, address step sizes and count rounding
	// ---------------------------------------------------------------
	localparam logic [2:0] CYC_NORMAL = 3'h4;
	localparam logic [2:0] CYC_SLOW = 3'h5;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_ODD_MASK = 16'hFFFE;
	// ---------------------------------------------------------------
	// Channel engine states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		CH_IDLE = 4'h1,
		CH_REQ = 4'h2,
		CH_CYC = 4'h4,
		CH_DONE = 4'h8
	} dds_ch_state_t;
endpackage

// *** verilog/dds_sequencer.sv ***
// Dual-channel DMA sequencer top: register port, command sequencing,
// remote halt/resume, tracking and external DMA, completion interrupt.
// Assumes a plain register port; ack, ext-wait and index pins synchronised here.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dds_sequencer (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [dds_pkg::DDS_ADDR_WIDTH_C-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic local_bus_ack_i,
	input wire logic remote_bus_ack_i,
	input wire logic ext_status_i,
	input wire logic index_pulse_i,
	input wire logic fifo_need_i,
	input wire logic sector_done_i,
	input wire logic disk_error_i,
	output logic local_bus_request_o,
	output logic remote_bus_request_o,
	output logic local_strobe_o,
	output logic remote_strobe_o,
	output logic [15:0] local_addr_o,
	output logic [15:0] remote_addr_o,
	output logic disk_run_o,
	output logic irq_o
);
	import dds_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] local_bus_ack_sync_reg, rack_sync_reg, ews_sync_reg, idx_sync_reg;
	logic local_bus_ack_q_reg, rack_q_reg, ews_q_reg, idx_q_reg, idx_prev_reg;
	logic local_bus_ack_s, rack_s, ews_s, idx_s, idx_rise;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			local_bus_ack_sync_reg <= '0;
			rack_sync_reg <= '0;
			ews_sync_reg <= '0;
			idx_sync_reg <= '0;
		end else begin
			local_bus_ack_sync_reg <= {local_bus_ack_sync_reg[1:0], local_bus_ack_i};
			rack_sync_reg <= {rack_sync_reg[1:0], remote_bus_ack_i};
			ews_sync_reg <= {ews_sync_reg[1:0], ext_status_i};
			idx_sync_reg <= {idx_sync_reg[1:0], index_pulse_i};
		end
	end

	// Accept a change only when stages two and three agree
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			local_bus_ack_q_reg <= 1'b0;
			rack_q_reg <= 1'b0;
			ews_q_reg <= 1'b0;
			idx_q_reg <= 1'b0;
			idx_prev_reg <= 1'b0;
		end else begin
			if (local_bus_ack_sync_reg[1] == local_bus_ack_sync_reg[2]) local_bus_ack_q_reg <= local_bus_ack_sync_reg[2];
			if (rack_sync_reg[1] == rack_sync_reg[2]) rack_q_reg <= rack_sync_reg[2];
			if (ews_sync_reg[1] == ews_sync_reg[2]) ews_q_reg <= ews_sync_reg[2];
			if (idx_sync_reg[1] == idx_sync_reg[2]) idx_q_reg <= idx_sync_reg[2];
			idx_prev_reg <= idx_q_reg;
		end
	end

	assign local_bus_ack_s = local_bus_ack_q_reg;
	assign rack_s = rack_q_reg;
	assign ews_s = ews_q_reg;
	assign idx_s = idx_q_reg;
	assign idx_rise = idx_s & ~idx_prev_reg;

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [7:0] laddr0_reg, laddr1_reg, raddr0_reg, raddr1_reg;
	logic [7:0] lxfer_reg, rxfer_reg, rcnt0_reg, rcnt1_reg, lcnt0_reg, lcnt1_reg;
	logic [7:0] secops_reg, seccnt_reg, opcmd_reg, drvcmd_reg;
	logic [7:0] status_reg, rdata_reg;
	logic wr_laddr, wr_raddr, wr_rcnt, wr_lcnt, wr_opcmd, wr_drvcmd, rd_status;
	logic oc_halt, oc_in, oc_out;

	assign wr_laddr = reg_wr_i && reg_addr_i == OFS_LADDR1;
	assign wr_raddr = reg_wr_i && reg_addr_i == OFS_RADDR1;
	assign wr_rcnt = reg_wr_i && reg_addr_i == OFS_RCNT1;
	assign wr_lcnt = reg_wr_i && reg_addr_i == OFS_LCNT1;
	assign wr_opcmd = reg_wr_i && reg_addr_i == OFS_OPCMD;
	assign wr_drvcmd = reg_wr_i && reg_addr_i == OFS_DRVCMD;
	assign rd_status = reg_rd_i && reg_addr_i == OFS_STATUS;
	assign oc_in = reg_wdata_i[OC_RIN];
	assign oc_out = reg_wdata_i[OC_ROUT];
	assign oc_halt = wr_opcmd & oc_in & oc_out;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			laddr0_reg <= '0;
			laddr1_reg <= '0;
			raddr0_reg <= '0;
			raddr1_reg <= '0;
			lxfer_reg <= '0;
			rxfer_reg <= '0;
			rcnt0_reg <= '0;
			rcnt1_reg <= '0;
			lcnt0_reg <= '0;
			lcnt1_reg <= '0;
			secops_reg <= '0;
			seccnt_reg <= '0;
			opcmd_reg <= '0;
			drvcmd_reg <= '0;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				OFS_LADDR0: laddr0_reg <= reg_wdata_i;
				OFS_LADDR1: laddr1_reg <= reg_wdata_i;
				OFS_RADDR0: raddr0_reg <= reg_wdata_i;
				OFS_RADDR1: raddr1_reg <= reg_wdata_i;
				OFS_LXFER: lxfer_reg <= reg_wdata_i;
				OFS_RXFER: rxfer_reg <= reg_wdata_i;
				OFS_RCNT0: rcnt0_reg <= reg_wdata_i;
				OFS_RCNT1: rcnt1_reg <= reg_wdata_i;
				OFS_LCNT0: lcnt0_reg <= reg_wdata_i;
				OFS_LCNT1: lcnt1_reg <= reg_wdata_i;
				OFS_SECOPS: secops_reg <= reg_wdata_i;
				OFS_SECCNT: seccnt_reg <= reg_wdata_i;
				// Halt pattern leaves the stored command for resume
				OFS_OPCMD: if (!oc_halt) opcmd_reg <= reg_wdata_i;
				OFS_DRVCMD: drvcmd_reg <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Remote channel control
	// ---------------------------------------------------------------
	logic rrun_reg, rhalt_reg, rdone_pulse, ldone_pulse;
	logic remote_en, local_en, track, extdma;
	logic [15:0] raddr_cur, rcnt_cur, laddr_cur, lcnt_cur;
	logic r_req, r_stb, l_req, l_stb;
	logic [7:0] track_cnt_reg;
	logic track_ok, remote_go;

	assign remote_en = rxfer_reg[XF_ENABLE];
	assign local_en = lxfer_reg[XF_ENABLE];
	assign track = rxfer_reg[XF_TRACK];
	assign extdma = lxfer_reg[XF_EXTDMA];

	assign track_ok = !track || track_cnt_reg != '0;
	assign remote_go = rrun_reg & remote_en & track_ok;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rrun_reg <= 1'b0;
			rhalt_reg <= 1'b0;
		end else if (oc_halt) begin
			rrun_reg <= 1'b0;
			rhalt_reg <= rrun_reg | rhalt_reg;
		end else if (wr_opcmd && (oc_in || oc_out)) begin
			rrun_reg <= 1'b1;
			rhalt_reg <= 1'b0;
		end else if (rdone_pulse) begin
			rrun_reg <= 1'b0;
		end
	end

	// Tracking sector difference, local source up, remote sink down
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			track_cnt_reg <= '0;
		end else if (sector_done_i && !rdone_pulse) begin
			track_cnt_reg <= track_cnt_reg + 8'h01;
		end else if (rdone_pulse && !sector_done_i && track_cnt_reg != '0) begin
			track_cnt_reg <= track_cnt_reg - 8'h01;
		end
	end

	dds_channel u_remote (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(remote_go),
		.load_addr_i(wr_raddr && !rhalt_reg),
		.addr_i({reg_wdata_i, raddr0_reg}),
		.load_cnt_i(wr_rcnt && !rhalt_reg),
		.cnt_i({reg_wdata_i, rcnt0_reg}),
		.word_i(rxfer_reg[XF_WORD]),
		.slow_i(rxfer_reg[XF_SLOW]),
		.extwait_en_i(rxfer_reg[XF_EXTWAIT]),
		.extwait_i(ews_s),
		.ack_i(rack_s),
		.req_o(r_req),
		.strobe_o(r_stb),
		.addr_o(raddr_cur),
		.cnt_o(rcnt_cur),
		.done_o(rdone_pulse)
	);

	// ---------------------------------------------------------------
	// Disk operation sequencing
	// ---------------------------------------------------------------
	logic disk_run_reg, wait_index_reg, lrun;
	logic multi_sector, ext_req;

	assign multi_sector = secops_reg != '0;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			disk_run_reg <= 1'b0;
			wait_index_reg <= 1'b0;
		end else if (wr_drvcmd && (reg_wdata_i[DC_WRITE] || reg_wdata_i[DC_READ])) begin
			wait_index_reg <= multi_sector && !reg_wdata_i[DC_START_AT_INDEX_CTL];
			disk_run_reg <= !(multi_sector && !reg_wdata_i[DC_START_AT_INDEX_CTL]);
		end else if (wait_index_reg && idx_rise) begin
			wait_index_reg <= 1'b0;
			disk_run_reg <= 1'b1;
		end else if (ldone_pulse || disk_error_i || (extdma && sector_done_i)) begin
			disk_run_reg <= 1'b0;
		end
	end

	assign ext_req = extdma & disk_run_reg & fifo_need_i;
	assign lrun = disk_run_reg & local_en & ~extdma;

	dds_channel u_local (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(lrun),
		.load_addr_i(wr_laddr),
		.addr_i({reg_wdata_i, laddr0_reg}),
		.load_cnt_i(wr_lcnt),
		.cnt_i({reg_wdata_i, lcnt0_reg}),
		.word_i(lxfer_reg[XF_WORD]),
		.slow_i(lxfer_reg[XF_SLOW]),
		.extwait_en_i(rxfer_reg[XF_EXTWAIT]),
		.extwait_i(ews_s),
		.ack_i(local_bus_ack_s),
		.req_o(l_req),
		.strobe_o(l_stb),
		.addr_o(laddr_cur),
		.cnt_o(lcnt_cur),
		.done_o(ldone_pulse)
	);

	// ---------------------------------------------------------------
	// Status, interrupt, outputs
	// ---------------------------------------------------------------
	logic opdone_set, rdone_set, irq_reg, lreq_reg, rreq_reg;
	logic lstb_reg, rstb_reg, run_out_reg;
	logic [15:0] laddr_out_reg, raddr_out_reg;

	assign opdone_set = ldone_pulse | disk_error_i | (extdma & disk_run_reg & sector_done_i);
	assign rdone_set = rdone_pulse;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_reg <= '0;
		end else begin
			status_reg[ST_OPDONE] <= opdone_set | (status_reg[ST_OPDONE] & ~rd_status);
			status_reg[ST_RDONE] <= rdone_set | (status_reg[ST_RDONE] & ~rd_status);
			status_reg[ST_RBUSY] <= rrun_reg;
			status_reg[ST_LBUSY] <= disk_run_reg;
			status_reg[ST_HALTED] <= rhalt_reg;
			status_reg[ST_WAITIDX] <= wait_index_reg;
			status_reg[7:6] <= '0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			irq_reg <= opcmd_reg[OC_INTEN] & (status_reg[ST_OPDONE] | status_reg[ST_RDONE]);
			if (!reg_rd_i) rdata_reg <= '0;
			else unique case (reg_addr_i)
				OFS_LADDR0: rdata_reg <= laddr_cur[7:0];
				OFS_LADDR1: rdata_reg <= laddr_cur[15:8];
				OFS_RADDR0: rdata_reg <= raddr_cur[7:0];
				OFS_RADDR1: rdata_reg <= raddr_cur[15:8];
				OFS_LXFER: rdata_reg <= lxfer_reg;
				OFS_RXFER: rdata_reg <= rxfer_reg;
				OFS_RCNT0: rdata_reg <= rcnt_cur[7:0];
				OFS_RCNT1: rdata_reg <= rcnt_cur[15:8];
				OFS_LCNT0: rdata_reg <= lcnt_cur[7:0];
				OFS_LCNT1: rdata_reg <= lcnt_cur[15:8];
				OFS_SECOPS: rdata_reg <= secops_reg;
				OFS_SECCNT: rdata_reg <= seccnt_reg;
				OFS_OPCMD: rdata_reg <= opcmd_reg;
				OFS_DRVCMD: rdata_reg <= drvcmd_reg;
				OFS_STATUS: rdata_reg <= status_reg;
				default: rdata_reg <= '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lreq_reg <= 1'b0;
			rreq_reg <= 1'b0;
			lstb_reg <= 1'b0;
			rstb_reg <= 1'b0;
			run_out_reg <= 1'b0;
			laddr_out_reg <= '0;
			raddr_out_reg <= '0;
		end else begin
			lreq_reg <= l_req | ext_req;
			rreq_reg <= r_req;
			lstb_reg <= l_stb;
			rstb_reg <= r_stb;
			run_out_reg <= disk_run_reg;
			laddr_out_reg <= laddr_cur;
			raddr_out_reg <= raddr_cur;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign local_bus_request_o = lreq_reg;
	assign remote_bus_request_o = rreq_reg;
	assign local_strobe_o = lstb_reg;
	assign remote_strobe_o = rstb_reg;
	assign local_addr_o = laddr_out_reg;
	assign remote_addr_o = raddr_out_reg;
	assign disk_run_o = run_out_reg;
	assign irq_o = irq_reg;

	property p_halt_stops;
		@(posedge clk_i) disable iff (sys_rst_i)
		oc_halt |=> !rrun_reg;
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop remote");

	property p_halt_hold;
		@(posedge clk_i) disable iff (sys_rst_i)
		rhalt_reg && !r_stb |=> $stable(raddr_cur) && $stable(rcnt_cur);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("remote position moved while halted");

	property p_resume;
		@(posedge clk_i) disable iff (sys_rst_i)
		rhalt_reg && wr_opcmd && oc_in && !oc_out |=> rrun_reg && raddr_cur == $past(raddr_cur);
	endproperty
	a_resume: assert property (p_resume) else $error("resume did not keep address");

	property p_index_wait;
		@(posedge clk_i) disable iff (sys_rst_i)
		wait_index_reg && !idx_rise |=> !disk_run_reg || $past(disk_run_reg);
	endproperty
	a_index_wait: assert property (p_index_wait) else $error("ran before index");

	property p_ext_req;
		@(posedge clk_i) disable iff (sys_rst_i)
		ext_req |=> local_bus_request_o;
	endproperty
	a_ext_req: assert property (p_ext_req) else $error("no local request in external mode");

	property p_irq;
		@(posedge clk_i) disable iff (sys_rst_i)
		rdone_pulse && opcmd_reg[OC_INTEN] |=> ##1 irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("no completion interrupt");

	property p_track;
		@(posedge clk_i) disable iff (sys_rst_i)
		track && track_cnt_reg == '0 |-> !remote_go;
	endproperty
	a_track: assert property (p_track) else $error("remote ran ahead of local");
endmodule
`default_nettype wire
